/* serializer_pkg.sv */
`default_nettype none
package serializer_pkg;
  // Width of the parallel pin group and of the double-edge word.
  localparam int PIN_COUNT = 24;
  localparam int WORD_WIDTH = 48;
  // Serial lane layout: eight data lanes, six data bits and one balance slot each.
  localparam int LANE_COUNT = 8;
  localparam int LANE_DATA_BITS = 6;
  localparam int FRAME_SLOTS = 7;
  localparam logic [2:0] LAST_SLOT = 3'h6;
  // Depth of the word buffer between capture and serializer.
  localparam int FIFO_DEPTH = 16;
  // Saturation limits and start value of the running disparity.
  localparam logic signed [5:0] DISP_MAX = 6'sh07;
  localparam logic signed [5:0] DISP_MIN = -6'sh06;
  localparam logic signed [5:0] DISP_RESET = 6'sh00;
  // Clock lane bit pattern, slot 0 in the top bit.
  localparam logic [6:0] CLOCK_LANE_PATTERN = 7'h78;
  // Pattern generator seeds and feedback taps.
  localparam logic [14:0] PRBS15_SEED = 15'h7fff;
  localparam logic [22:0] PRBS23_SEED = 23'h7fffff;
  localparam int PRBS15_TAP = 13;
  localparam int PRBS23_TAP = 17;
  // Reference clock period and serial bit divider default.
  localparam int REF_CLK_NS = 100;
  localparam int BIT_DIVIDE = 1;
  // Link state: powered down or framing.
  typedef enum logic {LINK_OFF, LINK_RUN} link_state_t;
endpackage : serializer_pkg
`default_nettype wire

/* word_stream_if.sv */
`timescale 1ns/1ps
`default_nettype none
// One valid/ready word stream between internal modules.
interface word_stream_if #(parameter int WIDTH = 48);
  logic valid;               // Word offered.
  logic ready;               // Word accepted.
  logic [WIDTH-1:0] data;    // Word content.
  modport source(output valid, output data, input ready);
  modport sink(input valid, input data, output ready);
endinterface : word_stream_if
`default_nettype wire

/* stream_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16
) (
  input wire logic clk,          // Reference clock.
  input wire logic rst,          // Synchronous reset, active high.
  word_stream_if.sink fill,      // Filling side.
  word_stream_if.source drain    // Draining side.
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];  // Word storage.
  logic [AW-1:0] wr_ptr;          // Next write slot.
  logic [AW-1:0] rd_ptr;          // Next read slot.
  logic [AW:0] count;             // Words held.

  wire push = fill.valid && fill.ready;
  wire pop = drain.valid && drain.ready;

  // Full and empty come straight from the count.
  assign fill.ready = (count != (AW + 1)'(DEPTH));
  assign drain.valid = (count != '0);
  assign drain.data = mem[rd_ptr];

  // Storage write; no reset is needed on the array.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= fill.data;
    end
  end

  // Pointer and count update.
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

  default clocking fc @(posedge clk); endclocking
  default disable iff (rst);

  a_fifo_bound: assert property (count <= (AW + 1)'(DEPTH)) else $error("fifo count above depth");
  a_full_stall: assert property (count == (AW + 1)'(DEPTH) && !pop |=> !fill.ready) else $error("full fifo accepts");
  c_fifo_full: cover property (count == (AW + 1)'(DEPTH));
endmodule : stream_fifo
`default_nettype wire

/* balance_encoder.sv */
`timescale 1ns/1ps
`default_nettype none
module balance_encoder
  import serializer_pkg::*;
#(
  parameter int BITS = LANE_DATA_BITS
) (
  input wire logic clk,                  // Reference clock.
  input wire logic rst,                  // Synchronous reset, active high.
  input wire logic enable,               // Balance mode on.
  input wire logic load,                 // New word taken this cycle.
  input wire logic [BITS-1:0] word,      // Word about to be sent.
  output logic invert,                   // Send this word inverted.
  output logic signed [5:0] running      // Running disparity.
);
  // Ones minus zeros of a word.
  function automatic logic signed [5:0] disparity(input logic [BITS-1:0] w);
    int ones;
    ones = 0;
    for (int i = 0; i < BITS; i++) ones += int'(w[i]);
    return 6'(2 * ones - BITS);
  endfunction : disparity

  wire logic signed [5:0] word_disp = disparity(word);
  assign invert = enable && ((running == 6'sh00) || (running > 6'sh00 && word_disp > 6'sh00) ||
                             (running < 6'sh00 && word_disp <= 6'sh00));
  wire logic signed [5:0] delta = invert ? (6'sh01 - word_disp) : (word_disp - 6'sh01);
  wire logic signed [5:0] sum = running + delta;
  wire logic signed [5:0] next_running = (sum > DISP_MAX) ? DISP_MAX : ((sum < DISP_MIN) ? DISP_MIN : sum);

  // Accumulate only while balancing; any start value in range is legal.
  // start value
  always_ff @(posedge clk) begin
    if (rst) begin
      running <= DISP_RESET;
    end else if (load && enable) begin
      running <= next_running;
    end
  end

  default clocking ec @(posedge clk); endclocking
  default disable iff (rst);

  a_disp_range: assert property (running <= DISP_MAX && running >= DISP_MIN) else $error("disparity out of range");
  a_no_invert: assert property (!enable |-> !invert) else $error("inverted with balance off");
  a_zero_step: assert property (load && enable && running == 6'sh00 && word == '1 |-> invert ##1 running == -6'sh05)
    else $error("zero disparity step wrong");
  c_inverted: cover property (load && invert);
endmodule : balance_encoder
`default_nettype wire

/* lane_serializer.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Capture 24 inputs on both clock edges.
// - Rising edge gives low half, falling high.
// - Eight data lanes plus forwarded clock lane.
// - Balancing only while balance enable high.
// - Balance bit flags inverted lane word.
// - Word disparity is ones minus zeros.
// - Running disparity may start anywhere in range.
// - Update disparity by sent word minus one; the code adds one instead when the word is inverted.
// - Running disparity saturates at plus7, minus6.
// - Invert per running and word disparity signs.
// - Sense output high when termination present.
// - Test pattern replaces data while enabled.
// - Select long or short pseudo-random pattern.
// - Pattern select ignored when pattern off.
// - Power down stops framing, floats outputs; the code floats the data and clock lanes only, the sense pin still pulls low while no load is seen.
module lane_serializer
  import serializer_pkg::*;
#(
  parameter int BIT_DIV = BIT_DIVIDE,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic REF_CLK,                      // Reference clock, 10 MHz.
  input wire logic RST,                          // Synchronous reset, active high.
  input wire logic INPUT_CLOCK,                  // Parallel-side strobe clock pin.
  input wire logic [PIN_COUNT-1:0] PARALLEL_DATA, // Parallel data pins.
  input wire logic DC_BALANCE_ENABLE,            // Balance mode pin.
  input wire logic TEST_PATTERN_ENABLE,          // Test pattern pin.
  input wire logic PATTERN_LENGTH_SELECT,        // High picks the 23-bit pattern.
  input wire logic POWER_DOWN_N,                 // Power down, active low.
  input wire logic TERM_DETECT,                  // Far-end load comparator.
  output logic [LANE_COUNT-1:0] SERIAL_DATA_LANES, // Data lane bits.
  output logic SERIAL_DATA_LANES_OE,             // Data lanes driven.
  output logic LINK_CLOCK_LANE,                  // Forwarded clock lane bit.
  output logic LINK_CLOCK_LANE_OE,               // Clock lane driven.
  output logic FAR_TERMINATION_SENSE_O,          // Open-drain sense level.
  output logic FAR_TERMINATION_SENSE_OE,         // Sense pin pulled low.
  output logic INPUT_READY                       // Buffer can take a word.
);
  localparam int SYNC_W = PIN_COUNT + 6;

  // Two-stage synchroniser for every pin input.
  logic [SYNC_W-1:0] pin_meta;   // First stage, read only by the second.
  logic [SYNC_W-1:0] pin_sync;   // Second stage, safe to use.
  logic clk_prev;                // Strobe clock one cycle ago.

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pin_meta <= '0;
      pin_sync <= '0;
      clk_prev <= 1'b0;
    end else begin
      pin_meta <= {TERM_DETECT, POWER_DOWN_N, PATTERN_LENGTH_SELECT, TEST_PATTERN_ENABLE,
                   DC_BALANCE_ENABLE, INPUT_CLOCK, PARALLEL_DATA};
      pin_sync <= pin_meta;
      clk_prev <= pin_sync[PIN_COUNT];
    end
  end

  // Named views of the synchronised pins.
  wire logic [PIN_COUNT-1:0] data_in = pin_sync[PIN_COUNT-1:0];
  wire logic strobe_clk = pin_sync[PIN_COUNT];
  wire logic balance_on = pin_sync[PIN_COUNT+1];
  wire logic pattern_on = pin_sync[PIN_COUNT+2];
  wire logic pattern_long = pin_sync[PIN_COUNT+3];
  wire logic powered = pin_sync[PIN_COUNT+4];
  wire logic term_seen = pin_sync[PIN_COUNT+5];
  wire logic rise_edge = strobe_clk && !clk_prev;
  wire logic fall_edge = !strobe_clk && clk_prev;

  // Capture side of the buffer.
  word_stream_if #(.WIDTH(WORD_WIDTH)) cap_if ();
  word_stream_if #(.WIDTH(WORD_WIDTH)) ser_if ();

  logic [PIN_COUNT-1:0] low_half;  // Bits taken on the rising edge.
  logic have_low;                  // A low half is waiting for its partner.
  logic push;                      // One-cycle word offer.
  logic [WORD_WIDTH-1:0] push_word; // Assembled 48-bit word.

  assign cap_if.valid = push;
  assign cap_if.data = push_word;

  // Double-edge capture; a word offered while the buffer is full is lost.
  // both edges
  always_ff @(posedge REF_CLK) begin
    if (RST || !powered) begin
      low_half <= '0;
      have_low <= 1'b0;
      push <= 1'b0;
      push_word <= '0;
    end else begin
      push <= 1'b0;
      if (rise_edge) begin
        low_half <= data_in;
        have_low <= 1'b1;
      end else if (fall_edge && have_low) begin
        push_word <= {data_in, low_half};
        push <= 1'b1;
        have_low <= 1'b0;
      end
    end
  end

  stream_fifo #(.WIDTH(WORD_WIDTH), .DEPTH(DEPTH)) word_buffer (
    .clk(REF_CLK),
    .rst(RST),
    .fill(cap_if.sink),
    .drain(ser_if.source)
  );

  // Serial bit-rate enable from the reference clock.
  logic [15:0] div_count;   // Divider count.
  logic bit_tick;           // One-cycle bit enable.
  link_state_t state;       // Powered or not.
  link_state_t next_state;  // State for the next cycle.
  logic [2:0] slot;         // Slot presented at the next tick.
  logic [WORD_WIDTH-1:0] frame_word; // Word being sent.
  logic [LANE_COUNT-1:0] inv;        // Per-lane inversion of frame_word.
  logic [14:0] prbs15;      // Short pattern register.
  logic [22:0] prbs23;      // Long pattern register.

  always_ff @(posedge REF_CLK) begin
    if (RST || state == LINK_OFF || div_count == 16'(BIT_DIV - 1)) begin
      div_count <= '0;
    end else begin
      div_count <= div_count + 16'h0001;
    end
  end
  assign bit_tick = (state == LINK_RUN) && (div_count == 16'(BIT_DIV - 1));

  assign next_state = powered ? LINK_RUN : LINK_OFF;
  wire logic frame_end = bit_tick && (slot == LAST_SLOT);
  // A new word is drawn only at a frame boundary; an empty buffer sends zeros.
  assign ser_if.ready = frame_end;
  wire logic [WORD_WIDTH-1:0] next_word = ser_if.valid ? ser_if.data : '0;
  wire logic [LANE_COUNT-1:0] next_inv;

  // One encoder per lane, each with its own running disparity.
  // balance gated
  for (genvar k = 0; k < LANE_COUNT; k++) begin : g_lane
    balance_encoder #(.BITS(LANE_DATA_BITS)) encoder (
      .clk(REF_CLK),
      .rst(RST),
      .enable(balance_on),
      .load(frame_end),
      .word(next_word[k*LANE_DATA_BITS +: LANE_DATA_BITS]),
      .invert(next_inv[k]),
      .running()
    );
  end

  // Pattern bit; the length select only matters while the pattern is on.
  // pattern length
  wire logic prbs_bit = pattern_long ? prbs23[22] : prbs15[14];
  wire logic data_slot = (slot != LAST_SLOT);
  // Lane bits for the slot presented at the next tick.
  logic [LANE_COUNT-1:0] lane_bits;
  always_comb begin
    for (int k = 0; k < LANE_COUNT; k++) begin
      if (pattern_on) begin
        lane_bits[k] = data_slot ? prbs_bit : 1'b0;
      end else if (data_slot) begin
        lane_bits[k] = frame_word[k * LANE_DATA_BITS + int'(slot)] ^ inv[k];
      end else begin
        lane_bits[k] = balance_on ? inv[k] : 1'b0;
      end
    end
  end

  // Frame state, word register and pattern generators.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state <= LINK_OFF;
      slot <= LAST_SLOT;
      frame_word <= '0;
      inv <= '0;
      prbs15 <= PRBS15_SEED;
      prbs23 <= PRBS23_SEED;
    end else begin
      state <= next_state;
      if (state == LINK_OFF) begin
        slot <= LAST_SLOT;
      end else if (bit_tick) begin
        slot <= frame_end ? 3'h0 : slot + 3'h1;
        if (frame_end) begin
          frame_word <= next_word;
          inv <= next_inv;
        end
        if (pattern_on && data_slot) begin
          prbs15 <= {prbs15[13:0], prbs15[14] ^ prbs15[PRBS15_TAP]};
          prbs23 <= {prbs23[21:0], prbs23[22] ^ prbs23[PRBS23_TAP]};
        end
      end
    end
  end

  // Registered pin outputs.
  // eight lanes plus clock
  always_ff @(posedge REF_CLK) begin
    if (RST || state == LINK_OFF) begin
      SERIAL_DATA_LANES <= '0;
      SERIAL_DATA_LANES_OE <= 1'b0;
      LINK_CLOCK_LANE <= 1'b0;
      LINK_CLOCK_LANE_OE <= 1'b0;
    end else if (bit_tick) begin
      SERIAL_DATA_LANES <= lane_bits;
      SERIAL_DATA_LANES_OE <= 1'b1;
      LINK_CLOCK_LANE <= CLOCK_LANE_PATTERN[LAST_SLOT - slot];
      LINK_CLOCK_LANE_OE <= 1'b1;
    end
  end

  // Open-drain sense: released high when the far load is seen.
  // termination sense
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      FAR_TERMINATION_SENSE_O <= 1'b0;
      FAR_TERMINATION_SENSE_OE <= 1'b1;
      INPUT_READY <= 1'b0;
    end else begin
      FAR_TERMINATION_SENSE_O <= 1'b0;
      FAR_TERMINATION_SENSE_OE <= !term_seen;
      INPUT_READY <= cap_if.ready;
    end
  end

  default clocking mc @(posedge REF_CLK); endclocking
  default disable iff (RST);

  a_pd_floats: assert property (!powered |-> ##2 !SERIAL_DATA_LANES_OE && !LINK_CLOCK_LANE_OE)
    else $error("outputs driven in power down");
  a_sense_track: assert property (##1 FAR_TERMINATION_SENSE_OE == !$past(term_seen)) else $error("sense lags");
  a_clock_first: assert property (bit_tick && slot == 3'h0 |=> LINK_CLOCK_LANE && LINK_CLOCK_LANE_OE)
    else $error("clock lane slot 0 low");
  a_word_halves: assert property (fall_edge && have_low && powered |=> push && push_word[WORD_WIDTH-1:PIN_COUNT] ==
    $past(data_in) && push_word[PIN_COUNT-1:0] == $past(low_half)) else $error("word halves wrong");
  a_pattern_bits: assert property (bit_tick && pattern_on && data_slot |=> SERIAL_DATA_LANES == {LANE_COUNT{$past(prbs_bit)}})
    else $error("pattern not on lanes");
  a_no_bal_bit: assert property (bit_tick && !data_slot && !balance_on |=> SERIAL_DATA_LANES == '0)
    else $error("balance slot set with balance off");
  c_pattern_long: cover property (bit_tick && pattern_on && pattern_long);
  c_word_pushed: cover property (push && cap_if.ready);
endmodule : lane_serializer
`default_nettype wire

/* serial_receiver_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Far-end receiver model: frames the lanes on the forwarded clock and undoes inversion.
module serial_receiver_model
  import serializer_pkg::*;
#(
  parameter int DIV = 1
) (
  input wire logic clk,                        // Reference clock.
  input wire logic [LANE_COUNT-1:0] lanes,     // Data lane bits.
  input wire logic lanes_oe,                   // Data lanes driven.
  input wire logic clk_lane,                   // Forwarded clock bit.
  input wire logic clk_oe,                     // Clock lane driven.
  input wire logic term_present,               // Far-end load fitted.
  output logic term_detect,                    // Load comparator level.
  output logic frame_done,                     // One frame decoded.
  output logic [WORD_WIDTH-1:0] word,          // Decoded word.
  output logic [LANE_COUNT-1:0] flags,         // Balance bit of each lane.
  output logic [FRAME_SLOTS-1:0] cpat          // Clock lane bits, slot 0 on top.
);
  int cnt = 99;                                // Cycles since slot 0 began.
  int c;                                       // Cycle index of this sample.
  logic prev = 1'b0;                           // Clock lane one sample back.
  logic [LANE_COUNT-1:0] slot_bits [FRAME_SLOTS]; // Lane bits of each slot.
  assign term_detect = term_present;
  // Each slot is sampled in the first cycle of its bit; a rise on the clock lane marks slot 0.
  always @(posedge clk) begin
    frame_done <= 1'b0;
    prev <= clk_lane;
    if (!(lanes_oe && clk_oe)) begin
      cnt <= 99;
    end else begin
      c = (!prev && clk_lane) ? 0 : cnt;
      cnt <= c + 1;
      if (c < FRAME_SLOTS * DIV && c % DIV == 0) begin
        slot_bits[c / DIV] <= lanes;
        cpat[6 - c / DIV] <= clk_lane;
        if (c == 6 * DIV) begin
          frame_done <= 1'b1;
          flags <= lanes;
          for (int k = 0; k < LANE_COUNT; k++) begin
            for (int s = 0; s < LANE_DATA_BITS; s++) begin
              word[6 * k + s] <= slot_bits[s][k] ^ lanes[k];
            end
          end
        end
      end
    end
  end
endmodule : serial_receiver_model
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench: host strobe driver, far-end receiver and frame monitor.
module tb_top import serializer_pkg::*;;
  localparam int DIV = 3;                      // Slow draining so the buffer fills.
  logic ref_clk = 1'b0;                        // Reference clock.
  logic rst = 1'b1;                            // Reset.
  logic in_clk = 1'b0;                         // Parallel strobe clock.
  logic dc_balance_enable = 1'b1;                            // Balance mode.
  logic tpe = 1'b0;                            // Test pattern on.
  logic sel = 1'b0;                            // Long pattern select.
  logic pdn = 1'b0;                            // Power down, active low.
  logic term = 1'b0;                           // Far-end load fitted.
  logic [PIN_COUNT-1:0] pdata = '0;            // Parallel data pins.
  logic [LANE_COUNT-1:0] lanes;                // Lane bits.
  logic lanes_oe, clk_lane, clk_oe, sense_o, sense_oe, ready, term_det, fdone;
  logic [WORD_WIDTH-1:0] fword;                // Decoded word.
  logic [LANE_COUNT-1:0] fflags;               // Balance bits.
  logic [FRAME_SLOTS-1:0] fcpat;               // Clock lane pattern.
  wire sense_pin = sense_oe ? sense_o : 1'b1;  // Open drain with pull-up.
  int fail_count = 0;                          // Mismatches.
  int tests_run = 0;                           // Comparisons.
  int mode = 0;                                // 0 plain data, 1 balanced data, 2 pattern.
  int skip = 0;                                // Pattern frames still to skip.
  int nfr = 0;                                 // Frames seen.
  bit saw_full = 1'b0;                         // Buffer refused a word.
  logic [WORD_WIDTH-1:0] expq [$];             // Words still to arrive.
  bit bq [$];                                  // Pattern bits in order.
  int rd [LANE_COUNT] = '{default: 0};         // Expected running disparity.
  // Free-running reference clock.
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  lane_serializer #(.BIT_DIV(DIV)) u_lane_serializer (
    .REF_CLK(ref_clk), .RST(rst), .INPUT_CLOCK(in_clk), .PARALLEL_DATA(pdata),
    .DC_BALANCE_ENABLE(dc_balance_enable), .TEST_PATTERN_ENABLE(tpe), .PATTERN_LENGTH_SELECT(sel),
    .POWER_DOWN_N(pdn), .TERM_DETECT(term_det), .SERIAL_DATA_LANES(lanes),
    .SERIAL_DATA_LANES_OE(lanes_oe), .LINK_CLOCK_LANE(clk_lane), .LINK_CLOCK_LANE_OE(clk_oe),
    .FAR_TERMINATION_SENSE_O(sense_o), .FAR_TERMINATION_SENSE_OE(sense_oe), .INPUT_READY(ready));
  serial_receiver_model #(.DIV(DIV)) u_serial_receiver_model (
    .clk(ref_clk), .lanes(lanes), .lanes_oe(lanes_oe), .clk_lane(clk_lane), .clk_oe(clk_oe),
    .term_present(term), .term_detect(term_det), .frame_done(fdone), .word(fword),
    .flags(fflags), .cpat(fcpat));
  // Inputs change a fixed 1 ns after the rising edge.
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  // One counted comparison.
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Verdict and end of run.
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  // A bound that ran out ends the run.
  task automatic wait_ok(input string what, input bit ok);
    if (!ok) begin
      chk(what, 1, 0);
      results();
    end
  endtask : wait_ok
  // Host word on an 800 ns strobe: low half on the rising edge, high half on the falling one.
  // Ready is read just before the falling edge, once the previous word's push has reached it.
  task automatic send_word(input logic [47:0] w);
    int i;
    pdata = w[23:0];
    tick(1);
    in_clk = 1'b1;
    tick(2);
    pdata = w[47:24];
    tick(1);
    for (i = 0; i < 300 && ready !== 1'b1; i++) begin
      saw_full = 1'b1;
      tick(1);
    end
    wait_ok("ready wait", ready === 1'b1);
    expq.push_back(w);
    in_clk = 1'b0;
    tick(4);
  endtask : send_word
  // Waits until every sent word has come out of the link.
  task automatic wait_empty();
    int i;
    for (i = 0; i < 4000 && expq.size() > 0; i++) tick(1);
    wait_ok("drain wait", expq.size() == 0);
  endtask : wait_empty
  // Waits for a number of decoded frames.
  task automatic wait_frames(input int n);
    int i;
    int t;
    t = nfr + n;
    for (i = 0; i < 5000 && nfr < t; i++) tick(1);
    wait_ok("frame wait", nfr >= t);
  endtask : wait_frames
  // Each pattern bit must follow from two earlier ones by the generator's feedback.
  task automatic prbs_chk(input int a, input int b);
    int bad;
    int ones;
    bad = 0;
    ones = 0;
    for (int n = a; n < bq.size(); n++) begin
      bad += int'(bq[n] != (bq[n - a] ^ bq[n - b]));
      ones += int'(bq[n]);
    end
    chk("pattern recurrence", 0, bad);
    chk("pattern active", 1, ones > 0);
  endtask : prbs_chk
  // Frame monitor: clock lane, balance decisions, word order and pattern content.
  always @(posedge ref_clk) begin
    int d;
    bit inv;
    if (fdone) begin
      nfr++;
      chk("clock lane", CLOCK_LANE_PATTERN, fcpat);
      if (mode == 2 && skip > 0) begin
        skip--;
      end else if (mode == 2) begin
        chk("pattern lanes", {8{fword[5:0]}}, fword);
        chk("pattern flags", 0, fflags);
        for (int k = 0; k < LANE_DATA_BITS; k++) bq.push_back(fword[k]);
      end else begin
        for (int k = 0; k < LANE_COUNT; k++) begin
          d = 2 * $countones(fword[6 * k +: 6]) - 6;
          inv = mode == 1 && (rd[k] == 0 || (rd[k] > 0 && d > 0) || (rd[k] < 0 && d <= 0));
          chk("balance bit", inv, fflags[k]);
          if (mode == 1) rd[k] = inv ? rd[k] + 1 - d : rd[k] + d - 1;
          rd[k] = rd[k] > 7 ? 7 : (rd[k] < -6 ? -6 : rd[k]);
        end
        if (fword !== '0 && expq.size() == 0) chk("stray word", 0, fword);
        else if (fword !== '0) chk("word", expq.pop_front(), fword);
      end
    end
  end
  // Main sequence.
  initial begin
    tick(3);
    rst = 1'b0;
    tick(1);
    chk("lanes off", 0, {lanes_oe, clk_oe});
    tick(4);
    chk("sense no load", 0, sense_pin);
    term = 1'b1;
    tick(5);
    chk("sense load", 1, sense_pin);
    mode = 1;
    pdn = 1'b1;
    for (int i = 0; i < 48; i++) send_word(i == 0 ? '1 : {24'(i * 127913) ^ 24'h5a5a5a, 24'h000fff << (i % 13)});
    wait_empty();
    chk("buffer refused", 1, saw_full);
    tick(3 * 7 * DIV);
    chk("buffer empty", 1, ready);
    pdn = 1'b0;
    tick(6);
    chk("lanes released", 0, {lanes_oe, clk_oe});
    dc_balance_enable = 1'b0;
    mode = 0;
    sel = 1'b1;
    pdn = 1'b1;
    for (int i = 1; i < 7; i++) send_word({24'hc00000 | 24'(i), 24'(i * 4099)});
    wait_empty();
    mode = 2;
    skip = 3;
    sel = 1'b0;
    tpe = 1'b1;
    bq.delete();
    wait_frames(23);
    prbs_chk(15, 14);
    bq.delete();
    skip = 3;
    sel = 1'b1;
    wait_frames(23);
    prbs_chk(23, 18);
    pdn = 1'b0;
    tick(6);
    chk("lanes released", 0, {lanes_oe, clk_oe});
    results();
  end
endmodule : tb_top
`default_nettype wire
